// >>> tspc_pkg.sv
// package: offsets, field layouts, reset values for trap status and priority control
package tspc_pkg;

  // ********************************************
  // register byte offsets
  // ********************************************
  localparam logic [7:0] TSPC_OFS_TRAP = 8'h00;
  localparam logic [7:0] TSPC_OFS_PRIO = 8'h04;
  localparam logic [7:0] TSPC_OFS_ISTAT = 8'h08;
  localparam logic [7:0] TSPC_OFS_IMASK = 8'h0C;
  localparam logic [7:0] TSPC_OFS_STATE = 8'h10;

  // ********************************************
  // trap and nesting control fields
  // ********************************************
  localparam int TSPC_B_NEST = 15;
  localparam int TSPC_B_OVA_F = 14;
  localparam int TSPC_B_OVB_F = 13;
  localparam int TSPC_B_COVA_F = 12;
  localparam int TSPC_B_COVB_F = 11;
  localparam int TSPC_B_OVA_TE = 10;
  localparam int TSPC_B_OVB_TE = 9;
  localparam int TSPC_B_COV_TE = 8;
  localparam int TSPC_B_SHIFT = 7;
  localparam int TSPC_B_DIV0 = 6;
  localparam int TSPC_B_DMA = 5;
  localparam int TSPC_B_MATH = 4;
  localparam int TSPC_B_ADDR = 3;
  localparam int TSPC_B_STACK = 2;
  localparam int TSPC_B_OSC = 1;
  localparam logic [15:0] TSPC_TRAP_IMPL = 16'hFFFE;
  localparam logic [15:0] TSPC_TRAP_RESET = 16'h0000;

  // ********************************************
  // priority register layout
  // ********************************************
  localparam int TSPC_NSRC = 4;
  localparam int TSPC_PW = 3;
  localparam int TSPC_FIELD_STRIDE = 4;
  localparam logic [15:0] TSPC_PRIO_IMPL = 16'h7777;
  localparam logic [15:0] TSPC_PRIO_RESET = 16'h4444;
  localparam logic [2:0] TSPC_PRIO_OFF = 3'h0;

  // ********************************************
  // software interrupt status bits
  // ********************************************
  localparam int TSPC_IW = 3;
  localparam int TSPC_I_MATH = 0;
  localparam int TSPC_I_DMA = 1;
  localparam int TSPC_I_SYS = 2;
  localparam logic [2:0] TSPC_IMASK_RESET = 3'h0;

  // source index of a field: 0 capture6, 1 compare5, 2 compare6, 3 compare7
  function automatic logic [2:0] tspc_field(input logic [15:0] r, input logic [1:0] idx);
    tspc_field = r[idx*TSPC_FIELD_STRIDE +: TSPC_PW];
  endfunction

endpackage

// >>> tspc_arb_if.sv
// interface: pending sources and priority fields toward the arbiter, winner back
`timescale 1ns/1ps
interface tspc_arb_if;
  logic [3:0] pend;
  logic [3:0][2:0] level;
  logic win_valid;
  logic [1:0] win_id;
  logic [2:0] win_level;
  modport ctrl (output pend, output level, input win_valid, input win_id, input win_level);
  modport arb (input pend, input level, output win_valid, output win_id, output win_level);
endinterface

// >>> tspc_prio_arb.sv
// priority arbiter: picks the pending enabled source of highest level
`timescale 1ns/1ps
module tspc_prio_arb
  import tspc_pkg::*;
(
  tspc_arb_if.arb a
);

  // ********************************************
  // selection
  // ********************************************
  // scan upward; strictly greater keeps the lower index on a tie
  always_comb begin
    a.win_valid = 1'b0;
    a.win_id = 2'd0;
    a.win_level = TSPC_PRIO_OFF;
    for (int i = 0; i < TSPC_NSRC; i++) begin
      if (a.pend[i] && a.level[i] != TSPC_PRIO_OFF && a.level[i] > a.win_level) begin
        a.win_valid = 1'b1;
        a.win_id = i[1:0];
        a.win_level = a.level[i];
      end
    end
  end

endmodule

// >>> tspc_trap_reg.sv
// trap register storage: software write, hardware set that wins over the write
`timescale 1ns/1ps
module tspc_trap_reg
  import tspc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] set_vec,
  output logic [15:0] value_q
);

  logic [15:0] value_d;

  // flags set from hardware or by a software write of one; clearing is by software write
  assign value_d = ((wr_en ? wr_data : value_q) | set_vec) & TSPC_TRAP_IMPL;

  // ********************************************
  // storage
  // ********************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= TSPC_TRAP_RESET;
    end else begin
      value_q <= value_d;
    end
  end

endmodule

// >>> tspc_top.sv
// top: apb registers, trap status flags, priority request presentation
// Function
// - nesting disable set: no request is presented while one is in service
// - accumulator A/B overflow flag set when its overflow causes a trap
// - separate catastrophic overflow flags for A and B set on their trap
// - ordinary overflow traps only while that accumulator's enable bit is set
// - shift error status set on math trap from invalid accumulator shift
// - divide by zero status set on math trap from division by zero
// - dma error status set whenever a dma controller error trap occurs
// - math error status set whenever any math error trap occurs
// - each source has 3-bit priority; all ones is level 7, highest
// - code one is lowest level; code zero disables the source entirely
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
module tspc_top
  import tspc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_a_overflow_evt,
  input wire logic acc_b_overflow_evt,
  input wire logic acc_a_catastrophic_evt,
  input wire logic acc_b_catastrophic_evt,
  input wire logic shift_error_evt,
  input wire logic divide_zero_evt,
  input wire logic dma_error_evt,
  input wire logic address_error_evt,
  input wire logic stack_error_evt,
  input wire logic oscillator_fail_evt,
  input wire logic [3:0] src_evt,
  input wire logic in_service,
  input wire logic [2:0] cpu_level,
  input wire logic src_ack,
  input wire logic [1:0] src_ack_id,
  output logic math_trap,
  output logic dma_trap,
  output logic irq_req,
  output logic [1:0] irq_id,
  output logic [2:0] irq_level,
  output logic irq
);

  // ********************************************
  // declarations
  // ********************************************
  tspc_arb_if arb_bus ();
  logic [15:0] trap_q;
  logic [15:0] prio_q;
  logic [15:0] prio_d;
  logic [2:0] istat_q;
  logic [2:0] istat_d;
  logic [2:0] imask_q;
  logic [2:0] imask_d;
  logic [3:0] pend_q;
  logic [3:0] pend_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic math_trap_q;
  logic dma_trap_q;
  logic irq_req_q;
  logic [1:0] irq_id_q;
  logic [2:0] irq_level_q;
  logic irq_q;
  logic [15:0] set_vec;
  logic [3:0] ack_vec;
  logic [3:0] src_on;
  logic [31:0] rd_mux;

  // ********************************************
  // register behaviour
  // ********************************************
  // zero wait states: pready one cycle after every setup
  // read data is captured at the setup edge, zero otherwise
  // pready, pslverr and prdata each stand for one cycle
  // back to back transfers need no idle cycle
  // unmapped address: pslverr with pready, write dropped
  // unmapped read returns zero
  // state word is read only; a write there is dropped quietly
  // state word packs cpu level, service, pending and request
  // trap word: every implemented bit is writable
  // writing one to a flag sets it, writing zero clears it
  // a hardware set in the write cycle beats the write
  // so firmware clears flags by read, modify and write
  // bit zero of the trap word always reads zero
  // overflow flags need their own trap enable
  // catastrophic flags share one trap enable
  // math summary flag follows every counted math cause
  // address, stack and oscillator flags are plain sticky bits
  // a cause held high sets its flag on every cycle
  // status word: read clears, a cause in the read cycle stays
  // mask word has the status layout and resets clear
  // reset: trap word clear, every priority field at level four
  // reset: status, mask and pending sources clear

  // ********************************************
  // apb decode
  // ********************************************
  wire setup = psel & ~penable;
  wire done = psel & penable & pready_q;
  wire wr_done = done & pwrite;
  wire rd_done = done & ~pwrite;
  wire hit_trap = paddr == TSPC_OFS_TRAP;
  wire hit_prio = paddr == TSPC_OFS_PRIO;
  wire hit_istat = paddr == TSPC_OFS_ISTAT;
  wire hit_imask = paddr == TSPC_OFS_IMASK;
  wire hit_state = paddr == TSPC_OFS_STATE;
  wire mapped = hit_trap | hit_prio | hit_istat | hit_imask | hit_state;
  wire wr_trap = wr_done & hit_trap;
  wire wr_prio = wr_done & hit_prio;
  wire wr_imask = wr_done & hit_imask;
  wire istat_clr = rd_done & hit_istat;
  wire rd_setup = setup & ~pwrite;
  wire bad_setup = setup & ~mapped;

  // ********************************************
  // read words
  // ********************************************
  // status shows its next value, so a cause in the setup cycle is read before the clear
  wire [31:0] rd_trap = {16'h0000, trap_q};
  wire [31:0] rd_prio = {16'h0000, prio_q};
  wire [31:0] rd_istat = {29'h0000_0000, istat_d};
  wire [31:0] rd_imask = {29'h0000_0000, imask_q};
  wire [31:0] rd_state = {18'h0000, irq_level_q, irq_id_q, irq_req_q, pend_q, in_service,
                          cpu_level};

  // read data, reserved and unimplemented bits read as zero
  assign rd_mux = hit_trap ? rd_trap :
                  hit_prio ? rd_prio :
                  hit_istat ? rd_istat :
                  hit_imask ? rd_imask :
                  hit_state ? rd_state :
                  32'h0000_0000;

  // ********************************************
  // trap cause events
  // ********************************************
  wire te_a = trap_q[TSPC_B_OVA_TE];
  wire te_b = trap_q[TSPC_B_OVB_TE];
  wire te_cov = trap_q[TSPC_B_COV_TE];
  wire ova_trap = acc_a_overflow_evt & te_a;
  wire ovb_trap = acc_b_overflow_evt & te_b;
  wire cova_trap = acc_a_catastrophic_evt & te_cov;
  wire covb_trap = acc_b_catastrophic_evt & te_cov;
  wire any_math = ova_trap | ovb_trap | cova_trap | covb_trap | shift_error_evt | divide_zero_evt;
  wire sys_trap = address_error_evt | stack_error_evt | oscillator_fail_evt;

  // set vector into the trap register; control bits are never set here
  always_comb begin
    set_vec = 16'h0000;
    // ordinary overflow flags
    set_vec[TSPC_B_OVA_F] = ova_trap;
    set_vec[TSPC_B_OVB_F] = ovb_trap;
    // catastrophic overflow flags
    set_vec[TSPC_B_COVA_F] = cova_trap;
    set_vec[TSPC_B_COVB_F] = covb_trap;
    // math causes, the dma error and the math summary
    set_vec[TSPC_B_SHIFT] = shift_error_evt;
    set_vec[TSPC_B_DIV0] = divide_zero_evt;
    set_vec[TSPC_B_DMA] = dma_error_evt;
    set_vec[TSPC_B_MATH] = any_math;
    // system causes
    set_vec[TSPC_B_ADDR] = address_error_evt;
    set_vec[TSPC_B_STACK] = stack_error_evt;
    set_vec[TSPC_B_OSC] = oscillator_fail_evt;
  end

  tspc_trap_reg u_trap (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(wr_trap),
    .wr_data(pwdata[15:0]),
    .set_vec(set_vec),
    .value_q(trap_q)
  );

  // ********************************************
  // priority fields and pending sources
  // ********************************************
  assign prio_d = wr_prio ? (pwdata[15:0] & TSPC_PRIO_IMPL) : prio_q;

  // a source whose field is zero is disabled and never latches
  always_comb begin
    for (int i = 0; i < TSPC_NSRC; i++) begin
      src_on[i] = tspc_field(prio_q, i[1:0]) != TSPC_PRIO_OFF;
      ack_vec[i] = src_ack & (src_ack_id == i[1:0]);
      arb_bus.level[i] = tspc_field(prio_q, i[1:0]);
    end
  end

  // new event wins over an acknowledge in the same cycle
  assign pend_d = (pend_q & ~ack_vec & src_on) | (src_evt & src_on);
  assign arb_bus.pend = pend_q;

  tspc_prio_arb u_arb (
    .a(arb_bus)
  );

  // ********************************************
  // request behaviour
  // ********************************************
  // priority field code zero drops the source
  // clearing a field also drops a pending source
  // the highest field wins; a tie goes to the lower index
  // a request is recomputed every cycle, not held after accept
  // an accept and a new event together keep the source pending
  // nesting disable blocks every request while one is serviced
  // otherwise only a level above the serviced one is shown
  // irq_level reads zero while no request is shown
  // math_trap and dma_trap repeat their causes one cycle later, registered
  // irq follows status and mask one cycle after the cause

  // ********************************************
  // request presentation
  // ********************************************
  wire nest_block = trap_q[TSPC_B_NEST] & in_service;
  wire lvl_above = arb_bus.win_level > cpu_level;
  wire beats_cpu = ~in_service | lvl_above;
  wire present = arb_bus.win_valid & ~nest_block & beats_cpu;

  // ********************************************
  // software interrupt status and mask
  // ********************************************
  wire [2:0] ievt = {sys_trap, dma_error_evt, any_math};
  // read clears, a coincident event survives
  assign istat_d = (istat_clr ? 3'h0 : istat_q) | ievt;
  assign imask_d = wr_imask ? pwdata[2:0] : imask_q;
  // interrupt level from the next status, unmasked bits only
  wire irq_d = |(istat_d & imask_q);

  // ********************************************
  // apb answer registers
  // ********************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= bad_setup;
      prdata_q <= rd_setup ? rd_mux : 32'h0000_0000;
    end
  end

  // ********************************************
  // control state
  // ********************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_q <= TSPC_PRIO_RESET;
      pend_q <= 4'h0;
      istat_q <= 3'h0;
      imask_q <= TSPC_IMASK_RESET;
    end else begin
      prio_q <= prio_d;
      pend_q <= pend_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
    end
  end

  // ********************************************
  // core facing outputs
  // ********************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      math_trap_q <= 1'b0;
      dma_trap_q <= 1'b0;
      irq_req_q <= 1'b0;
      irq_id_q <= 2'd0;
      irq_level_q <= TSPC_PRIO_OFF;
      irq_q <= 1'b0;
    end else begin
      math_trap_q <= any_math;
      dma_trap_q <= dma_error_evt;
      irq_req_q <= present;
      irq_id_q <= present ? arb_bus.win_id : 2'd0;
      irq_level_q <= present ? arb_bus.win_level : TSPC_PRIO_OFF;
      irq_q <= irq_d;
    end
  end

  // ********************************************
  // port drive
  // ********************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign math_trap = math_trap_q;
  assign dma_trap = dma_trap_q;
  assign irq_req = irq_req_q;
  assign irq_id = irq_id_q;
  assign irq_level = irq_level_q;
  assign irq = irq_q;

endmodule

// >>> tspc_top_sva.sv
// checker: port properties of trap status and priority control
`timescale 1ns/1ps
module tspc_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic shift_error_evt,
  input wire logic divide_zero_evt,
  input wire logic dma_error_evt,
  input wire logic in_service,
  input wire logic [2:0] cpu_level,
  input wire logic math_trap,
  input wire logic dma_trap,
  input wire logic irq_req,
  input wire logic [2:0] irq_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answer, trap cause and request relations
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  shift_trap_a: assert property (shift_error_evt |=> math_trap)
    else $error("shift error gave no math trap");
  div_trap_a: assert property (divide_zero_evt |=> math_trap)
    else $error("divide by zero gave no math trap");
  dma_trap_a: assert property (dma_trap == $past(dma_error_evt))
    else $error("dma trap not one cycle after its cause");
  req_level_a: assert property (irq_req |-> irq_level != 3'h0)
    else $error("request at level zero");
  no_preempt_a: assert property (irq_req && $past(in_service) |-> irq_level > $past(cpu_level))
    else $error("request not above level in service");
  // main scenarios reached
  cover property (math_trap && dma_trap);
  cover property (irq_req && irq_level == 3'h7);
  cover property (pslverr);
endmodule

bind tspc_top tspc_top_chk chk (.*);

// >>> tspc_core_model.sv
// partner: core side that accepts presented interrupt requests
`timescale 1ns/1ps
module tspc_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ack_en,
  input wire logic [3:0] delay,
  input wire logic irq_req,
  input wire logic [1:0] irq_id,
  output logic src_ack,
  output logic [1:0] src_ack_id
);
  logic [3:0] wait_q;
  // accept after delay plus two cycles; the count restarts on accept so stale requests pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      src_ack <= 1'b0;
      src_ack_id <= 2'h0;
    end else begin
      src_ack <= irq_req && ack_en && wait_q == delay + 4'h2;
      src_ack_id <= irq_id;
      wait_q <= (irq_req && ack_en && !src_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

// >>> test_trap_status_and_priority_control.sv
// testbench: registers, trap flags, interrupt and priority presentation
`timescale 1ns/1ps
module test_trap_status_and_priority_control;
  import tspc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [9:0] evt = 10'h000;
  logic [3:0] src_evt = 4'h0, delay = 4'h0;
  logic in_service = 1'b0, ack_en = 1'b1, pready, pslverr, src_ack, irq_req, irq, err;
  logic [2:0] cpu_level = 3'h0, irq_level;
  logic math_trap, dma_trap;
  logic [1:0] src_ack_id, irq_id;
  int bad_count, tests_run, cyc;
  tspc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc_a_overflow_evt(evt[0]), .acc_b_overflow_evt(evt[1]),
    .acc_a_catastrophic_evt(evt[2]), .acc_b_catastrophic_evt(evt[3]),
    .shift_error_evt(evt[4]), .divide_zero_evt(evt[5]), .dma_error_evt(evt[6]),
    .address_error_evt(evt[7]), .stack_error_evt(evt[8]), .oscillator_fail_evt(evt[9]),
    .src_evt(src_evt), .in_service(in_service), .cpu_level(cpu_level), .src_ack(src_ack),
    .src_ack_id(src_ack_id), .math_trap(math_trap), .dma_trap(dma_trap), .irq_req(irq_req),
    .irq_id(irq_id), .irq_level(irq_level), .irq(irq));
  tspc_core_model core (.pclk(pclk), .presetn(presetn), .ack_en(ack_en), .delay(delay),
    .irq_req(irq_req), .irq_id(irq_id), .src_ack(src_ack), .src_ack_id(src_ack_id));
  // clock and hang limit
  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_hi(ref logic s);
    @(posedge pclk);
    while (s !== 1'b1) begin
      @(posedge pclk);
    end
  endtask
  // one apb transfer, read data and error kept in rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pulse(input logic [9:0] e, input logic [3:0] s);
    evt <= e;
    src_evt <= s;
    @(posedge pclk);
    evt <= 10'h000;
    src_evt <= 4'h0;
    @(posedge pclk);
  endtask
  task automatic expect_req(input logic [1:0] id, input logic [2:0] lvl, input logic [3:0] d);
    delay <= d;
    wait_hi(irq_req);
    chk(32'({irq_id, irq_level}), 32'({id, lvl}));
    wait_hi(src_ack);
    @(posedge pclk);
  endtask
  task automatic reset_and_map();
    apb(1'b0, TSPC_OFS_TRAP, 32'h0000_0000);
    chk(rd, {16'h0000, TSPC_TRAP_RESET});
    apb(1'b0, TSPC_OFS_PRIO, 32'h0000_0000);
    chk(rd, {16'h0000, TSPC_PRIO_RESET});
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
  endtask
  task automatic trap_flags();
    int bitpos[10] = '{14, 13, 12, 11, 7, 6, 5, 3, 2, 1};
    logic [31:0] exp;
    logic [31:0] tex;
    pulse(10'h005, 4'h0);
    chk(32'({math_trap, dma_trap}), 32'h0000_0000);
    apb(1'b0, TSPC_OFS_TRAP, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, TSPC_OFS_TRAP, 32'h0000_0700);
    exp = 32'h0000_0700;
    for (int i = 0; i < 10; i++) begin
      pulse(10'h001 << i, 4'h0);
      tex = (i < 6) ? 32'h0000_0002 : 32'(i == 6);
      chk(32'({math_trap, dma_trap}), tex);
      exp = exp | (32'h0000_0001 << bitpos[i]) | ((i < 6) ? 32'h0000_0010 : 32'h0000_0000);
      apb(1'b0, TSPC_OFS_TRAP, 32'h0000_0000);
      chk(rd, exp);
    end
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, TSPC_OFS_TRAP, 32'h0000_0000);
    apb(1'b0, TSPC_OFS_TRAP, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic irq_flow();
    apb(1'b1, TSPC_OFS_IMASK, 32'h0000_0001);
    @(posedge pclk);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b0, TSPC_OFS_ISTAT, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    @(posedge pclk);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b0, TSPC_OFS_ISTAT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask
  // capture6 disabled, compare6 and compare7 tie at 7, compare5 lowest
  task automatic priority_order();
    apb(1'b1, TSPC_OFS_PRIO, 32'h0000_7710);
    pulse(10'h000, 4'hF);
    expect_req(2'h2, 3'h7, 4'h0);
    expect_req(2'h3, 3'h7, 4'h4);
    expect_req(2'h1, 3'h1, 4'h1);
    repeat (8) @(posedge pclk);
    chk(32'(irq_req), 32'h0000_0000);
  endtask
  task automatic nesting();
    ack_en <= 1'b0;
    in_service <= 1'b1;
    apb(1'b1, TSPC_OFS_TRAP, 32'h0000_8000);
    pulse(10'h000, 4'h8);
    repeat (4) @(posedge pclk);
    chk(32'(irq_req), 32'h0000_0000);
    apb(1'b1, TSPC_OFS_TRAP, 32'h0000_0000);
    @(posedge pclk);
    chk(32'({irq_req, irq_level}), 32'h0000_000F);
    cpu_level <= 3'h7;
    repeat (3) @(posedge pclk);
    chk(32'(irq_req), 32'h0000_0000);
    in_service <= 1'b0;
    ack_en <= 1'b1;
    expect_req(2'h3, 3'h7, 4'h2);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_and_map();
    trap_flags();
    irq_flow();
    priority_order();
    nesting();
    print_verdict();
  end
endmodule
